// File: logic/bridge_pkg.sv
// Constants, register map and types shared by the conference bridge design.
package bridge_pkg;

    localparam int unsigned NUM_CHANS    = 8;
    localparam int unsigned CHAN_W       = 3;
    localparam int unsigned CODE_W       = 8;
    localparam int unsigned LIN_W        = 14;
    localparam int unsigned SCALE_W      = 16;
    localparam int unsigned SCALE_FRAC   = 15;
    localparam int unsigned COEF_W       = 16;
    localparam int unsigned COEF_FRAC    = 14;
    localparam int unsigned STATE_W      = 24;
    localparam int unsigned NUM_COEFS    = 4;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;

    // Timing: processing clock and telephony sample rate.
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned SAMPLE_HZ       = 8000;
    localparam int unsigned PERIOD_CYCLES   = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned PERIOD_W        = 12;

    // Table base values selecting the expansion law.
    localparam logic [15:0] TABLE_MU        = 16'h0100;
    localparam logic [15:0] TABLE_A         = 16'h0180;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_TABLE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SILENCE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_NCHANS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_COEF    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SCALE   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IO      = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_STATE   = 8'h60;

    // Status register fields.
    localparam int unsigned ST_SPK_LSB  = 0;
    localparam int unsigned ST_BUSY     = 4;
    localparam int unsigned ST_OVERRUN  = 5;

    // Reset values.
    localparam logic [15:0]        RST_TABLE   = TABLE_MU;
    localparam logic [CODE_W-1:0]  RST_SILENCE = 8'hff;
    localparam logic [3:0]         RST_NCHANS  = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CHAN,
        ST_ROUTE
    } bridge_state_e;

endpackage : bridge_pkg

// File: logic/conference_bridge.sv
// Loudest-speaker conference bridge datapath with Avalon-MM configuration registers.
// Function
// [RULE_01] Samples are 8-bit companded codes, both laws.
// [RULE_02] Table word 100h picks Mu-law, 180h A-law.
// [RULE_03] Top bit is sign, ignored; magnitude expands non-negative.
// [RULE_04] Linear magnitude times channel scale before integration.
// [RULE_05] Same-numbered channels across bridges share scale.
// [RULE_06] Eight consecutive scale words, word N for channel N.
// [RULE_07] Two-pole IIR power estimate, four coefficient words.
// [RULE_08] Coefficient addressing wraps modulo four.
// [RULE_09] Two state words per channel, updated each period.
// [RULE_10] Largest integrator output becomes current speaker.
// [RULE_11] Listeners get speaker code; speaker gets silence.
// [RULE_12] Silence code is a configurable word.
// [RULE_13] Forwarded code is speaker's original input, bit-exact.
// [RULE_14] One shared input/output table word per channel.
// [RULE_15] Channel-count word sets exactly how many channels run; a count of zero still runs channel 0 alone.
// [RULE_16] Whole bridge completes once per 8 kHz period.
// [RULE_17] Controller may rewrite configuration at any time.
// [RULE_18] Up to eight channels per bridge.
// [RULE_19] Ties go to the lowest-numbered channel.
`timescale 1ns/1ps
module conference_bridge
    import bridge_pkg::*;
(
    // Clock and reset.
    input  wire logic                core_clk,
    input  wire logic                srst,
    // Avalon-MM register slave.
    input  wire logic [ADDR_W-1:0]   address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [DATA_W-1:0]   writedata,
    input  wire logic [3:0]          byteenable,
    output logic      [DATA_W-1:0]   readdata,
    output logic                     waitrequest,
    // Incoming samples from the exchange tables.
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire logic [CHAN_W-1:0]   in_chan,
    input  wire logic [CODE_W-1:0]   in_code,
    // Outgoing samples to the exchange tables.
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic      [CHAN_W-1:0]   out_chan,
    output logic      [CODE_W-1:0]   out_code
);

    // Expands the seven magnitude bits of a companded code; the sign is dropped.
    function automatic logic [LIN_W-1:0] expand(input logic [CODE_W-1:0] code,
                                                input logic             a_law);
        logic [6:0]  mag;
        logic [2:0]  ex;
        logic [3:0]  man;
        logic [LIN_W:0] v;
        mag = 7'h00;
        ex  = 3'h0;
        man = 4'h0;
        v   = '0;
        if (a_law)
        begin
            mag = code[6:0] ^ 7'h55;
            ex  = mag[6:4];
            man = mag[3:0];
            if (ex == 3'h0)
                v = {7'h00, man, 4'h8};
            else
                v = 15'({6'h00, man, 4'h8} + 15'h0100) << (ex - 3'h1);
        end
        else
        begin
            mag = ~code[6:0];
            ex  = mag[6:4];
            man = mag[3:0];
            v   = 15'(({8'h00, man, 3'h0} + 15'h0084) << ex) - 15'h0084;
        end
        return v[LIN_W:1];
    endfunction : expand

    // Clamps a wide signed sum into the filter state width.
    function automatic logic signed [STATE_W-1:0] sat(input logic signed [47:0] v);
        logic signed [47:0] hi;
        logic signed [47:0] lo;
        hi = 48'sh0000007fffff;
        lo = -48'sh000000800000;
        if (v > hi)
            return STATE_W'(hi);
        else if (v < lo)
            return STATE_W'(lo);
        else
            return STATE_W'(v);
    endfunction : sat

    // Byte-lane merge for partial writes.
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [3:0]        be);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction : merge

    // Configuration and working storage.
    logic [15:0]                 table_base;
    logic [CODE_W-1:0]           silence;
    logic [3:0]                  nchans;
    logic signed [COEF_W-1:0]    coef      [NUM_COEFS];
    logic [SCALE_W-1:0]          scale     [NUM_CHANS];
    logic [CODE_W-1:0]           io_table  [NUM_CHANS];
    logic signed [STATE_W-1:0]   w1        [NUM_CHANS];
    logic signed [STATE_W-1:0]   w2        [NUM_CHANS];

    bridge_state_e               state;
    logic [CHAN_W-1:0]           ch;
    logic [CHAN_W-1:0]           speaker;
    logic [CHAN_W-1:0]           best_ch;
    logic [CODE_W-1:0]           best_code;
    logic signed [STATE_W-1:0]   best_pow;
    logic                        have_best;
    logic [PERIOD_W-1:0]         period_cnt;
    logic                        tick;
    logic                        overrun;
    logic                        ack;

    // Bus decode.
    logic                        req;
    logic                        sel_io;
    logic                        io_stall;
    logic                        bus_wr;
    logic [CHAN_W-1:0]           wsel;
    logic [1:0]                  csel;
    logic [3:0]                  last_ch;
    logic                        last;

    assign req      = read | write;
    assign sel_io   = (address >= OFS_IO) && (address < OFS_STATE);
    assign io_stall = write & sel_io & (state == ST_ROUTE);
    assign bus_wr   = write & ~ack & ~io_stall;
    assign wsel     = address[CHAN_W+1:2];
    assign csel     = address[3:2];
    assign waitrequest = req & ~ack;

    // As many channels as configured run, at least one (channel 0 for a count of zero) and never above eight.
    assign last_ch  = (nchans > 4'(NUM_CHANS)) ? 4'(NUM_CHANS - 1) :
                      (nchans == 4'h0) ? 4'h0 : nchans - 4'h1;  // see [RULE_15] see [RULE_18]
    assign last     = ({1'b0, ch} == last_ch);

    // Sample period strobe from the processing clock.
    always_ff @(posedge core_clk)
    begin
        if (srst || tick)
            period_cnt <= '0;
        else
            period_cnt <= period_cnt + PERIOD_W'(1);
    end
    assign tick = (period_cnt == PERIOD_W'(PERIOD_CYCLES - 1));  // see [RULE_16]

    // Channel datapath: expand, scale, then two-pole direct form II.
    logic                        a_law;
    logic [CODE_W-1:0]           cur_code;
    logic [LIN_W-1:0]            lin;
    logic [LIN_W+SCALE_W-1:0]    prod;
    logic signed [STATE_W-1:0]   x_in;
    logic signed [47:0]          fb;
    logic signed [47:0]          ff;
    logic signed [STATE_W-1:0]   w0;
    logic signed [STATE_W-1:0]   pow;
    logic [1:0]                  cp;

    assign a_law    = (table_base == TABLE_A);  // see [RULE_02]
    assign cur_code = io_table[ch];  // see [RULE_14]
    assign lin      = expand(cur_code, a_law);  // see [RULE_01] see [RULE_03]
    assign prod     = lin * scale[ch];  // see [RULE_04] see [RULE_05] see [RULE_06]
    assign x_in     = STATE_W'(prod >> SCALE_FRAC);
    assign cp       = 2'h0;
    // Coefficients are fetched by a two-bit offset from the area base, so they wrap.
    assign fb = ((48'(coef[cp])          * 48'(w1[ch])) +
                 (48'(coef[cp + 2'h1])   * 48'(w2[ch]))) >>> COEF_FRAC;  // see [RULE_08]
    assign w0 = sat(48'(x_in) + fb);  // see [RULE_07]
    assign ff = ((48'(coef[cp + 2'h2])   * 48'(w1[ch])) +
                 (48'(coef[cp + 2'h3])   * 48'(w2[ch]))) >>> COEF_FRAC;
    assign pow = sat(48'(w0) + ff);

    // Two-entry output buffer.
    logic [CHAN_W+CODE_W-1:0]    obuf [2];
    logic                        wr_ptr;
    logic                        rd_ptr;
    logic [1:0]                  count;
    logic                        push;
    logic                        pop;
    logic                        buf_ready;
    logic [CODE_W-1:0]           route_code;

    assign buf_ready  = (count != 2'h2);
    assign push       = (state == ST_ROUTE) & buf_ready;
    assign pop        = out_valid & out_ready;
    assign out_valid  = (count != 2'h0);
    assign route_code = (ch == speaker) ? silence : best_code;  // see [RULE_11] see [RULE_12] see [RULE_13]
    assign in_ready   = (state == ST_IDLE) & ~(bus_wr & sel_io);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                obuf[wr_ptr] <= {ch, route_code};
                wr_ptr       <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            count <= count + 2'(push) - 2'(pop);
        end
    end
    assign {out_chan, out_code} = obuf[rd_ptr];

    // Sequencer: one channel per cycle, then routing into the buffer.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state     <= ST_IDLE;
            ch        <= '0;
            speaker   <= '0;
            best_ch   <= '0;
            best_code <= '0;
            best_pow  <= '0;
            have_best <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (tick)
                    begin
                        state     <= ST_CHAN;
                        ch        <= '0;
                        have_best <= 1'b0;
                    end
                end
                ST_CHAN:
                begin
                    // Strict compare keeps the earliest channel on a tie.
                    if (!have_best || pow > best_pow)  // see [RULE_10] see [RULE_19]
                    begin
                        best_pow  <= pow;
                        best_ch   <= ch;
                        best_code <= cur_code;
                    end
                    have_best <= 1'b1;
                    if (last)
                    begin
                        state <= ST_ROUTE;
                        ch    <= '0;
                        speaker <= (!have_best || pow > best_pow) ? ch : best_ch;
                        if (!have_best || pow > best_pow)
                            best_code <= cur_code;
                    end
                    else
                        ch <= ch + CHAN_W'(1);
                end
                ST_ROUTE:
                begin
                    if (push)
                    begin
                        if (last)
                            state <= ST_IDLE;
                        else
                            ch <= ch + CHAN_W'(1);
                    end
                end
            endcase
        end
    end

    // Filter state, two words per channel.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NUM_CHANS; i++)
            begin
                w1[i] <= '0;
                w2[i] <= '0;
            end
        end
        else if (state == ST_CHAN)
        begin
            w1[ch] <= w0;  // see [RULE_09]
            w2[ch] <= w1[ch];
        end
    end

    // Shared sample table: routing writes back, then stream input, then bus.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NUM_CHANS; i++)
                io_table[i] <= RST_SILENCE;
        end
        else if (push)
            io_table[ch] <= route_code;  // see [RULE_14]
        else if (in_valid && in_ready)
            io_table[in_chan] <= in_code;
        else if (bus_wr && sel_io)
            io_table[wsel] <= CODE_W'(merge(32'(io_table[wsel]), writedata, byteenable));
    end

    // Configuration registers, writable at any time.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            table_base <= RST_TABLE;
            silence    <= RST_SILENCE;
            nchans     <= RST_NCHANS;
            for (int i = 0; i < NUM_COEFS; i++)
                coef[i] <= '0;
            for (int i = 0; i < NUM_CHANS; i++)
                scale[i] <= '0;
        end
        else if (bus_wr)
        begin
            // Changes take effect on the next channel evaluated.
            if (address[7:2] == OFS_TABLE[7:2])  // see [RULE_17]
                table_base <= 16'(merge(32'(table_base), writedata, byteenable));
            if (address[7:2] == OFS_SILENCE[7:2])
                silence <= CODE_W'(merge(32'(silence), writedata, byteenable));
            if (address[7:2] == OFS_NCHANS[7:2])
                nchans <= 4'(merge(32'(nchans), writedata, byteenable));
            if (address[7:4] == OFS_COEF[7:4])
                coef[csel] <= COEF_W'(merge(32'(coef[csel]), writedata, byteenable));
            if (address[7:5] == OFS_SCALE[7:5])
                scale[wsel] <= SCALE_W'(merge(32'(scale[wsel]), writedata, byteenable));
        end
    end

    // Overrun: a period tick while still busy. Set wins over a write-one clear.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            overrun <= 1'b0;
        else if (tick && state != ST_IDLE)
            overrun <= 1'b1;
        else if (bus_wr && address[7:2] == OFS_STATUS[7:2] && byteenable[0]
                 && writedata[ST_OVERRUN])
            overrun <= 1'b0;
    end

    // Bus answer one cycle after the request, later for a table write during routing, with read data registered.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ack      <= 1'b0;
            readdata <= '0;
        end
        else
        begin
            ack <= req & ~ack & ~io_stall;
            if (read && !ack)
            begin
                readdata <= '0;
                if (address[7:2] == OFS_TABLE[7:2])
                    readdata <= 32'(table_base);
                else if (address[7:2] == OFS_SILENCE[7:2])
                    readdata <= 32'(silence);
                else if (address[7:2] == OFS_NCHANS[7:2])
                    readdata <= 32'(nchans);
                else if (address[7:2] == OFS_STATUS[7:2])
                begin
                    readdata[ST_SPK_LSB +: CHAN_W] <= speaker;
                    readdata[ST_BUSY]              <= (state != ST_IDLE);
                    readdata[ST_OVERRUN]           <= overrun;
                end
                else if (address[7:4] == OFS_COEF[7:4])
                    readdata <= 32'(unsigned'(coef[csel]));
                else if (address[7:5] == OFS_SCALE[7:5])
                    readdata <= 32'(scale[wsel]);
                else if (sel_io)
                    readdata <= 32'(io_table[wsel]);
                else if (address >= OFS_STATE && address < OFS_STATE + 8'h40)
                    readdata <= address[2] ? 32'(unsigned'(w2[3'((address - OFS_STATE) >> 3)]))
                                           : 32'(unsigned'(w1[3'((address - OFS_STATE) >> 3)]));
            end
        end
    end

endmodule : conference_bridge

// File: bench/bridge_checker.sv
// Port checker for the conference bridge.
`timescale 1ns/1ps
module bridge_checker
    import bridge_pkg::*;
(
    // Clock and reset.
    input wire logic              core_clk,
    input wire logic              srst,
    // Register bus.
    input wire logic [ADDR_W-1:0] address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic              waitrequest,
    // Sample streams.
    input wire logic              in_ready,
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire logic [CHAN_W-1:0] out_chan,
    input wire logic [CODE_W-1:0] out_code
);
    logic [PERIOD_W-1:0] idle_cnt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // Counts how long the sequencer has sat idle since its last period.
    always_ff @(posedge core_clk)
    begin
        if (srst || !in_ready)
            idle_cnt <= '0;
        else
            idle_cnt <= idle_cnt + 1'b1;
    end

    sequence s_held;
        out_valid && $stable(out_chan) && $stable(out_code);
    endsequence
    property p_hold;
        out_valid && !out_ready |=> s_held;
    endproperty
    property p_rd_ack;
        read && waitrequest |=> !waitrequest;
    endproperty
    property p_wr_ack;
        write && waitrequest && address < OFS_IO |=> !waitrequest;
    endproperty
    property p_idle;
        !read && !write |-> !waitrequest;
    endproperty
    property p_rst;
        disable iff (1'b0) srst |=> readdata == '0 && !out_valid;
    endproperty
    property p_io_block;
        write && waitrequest && address >= OFS_IO && address < OFS_STATE |-> !in_ready;
    endproperty
    property p_rdata;
        !read |=> $stable(readdata);
    endproperty
    property p_busy;
        !in_ready |-> ##[0:300] in_ready;
    endproperty
    property p_period;
        idle_cnt <= PERIOD_CYCLES;
    endproperty

    a_hold: assert property (p_hold) else $error("output word changed while stalled");
    a_rd_ack: assert property (p_rd_ack) else $error("read answer late");
    a_wr_ack: assert property (p_wr_ack) else $error("write answer late");
    a_idle: assert property (p_idle) else $error("waitrequest without request");
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    a_io_block: assert property (p_io_block) else $error("input taken during table write");
    a_rdata: assert property (p_rdata) else $error("read data moved without read");
    a_busy: assert property (p_busy) else $error("processing overran");
    a_period: assert property (p_period) else $error("sample period missed");
endmodule : bridge_checker

bind conference_bridge bridge_checker u_chk (
    .core_clk(core_clk), .srst(srst), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .in_ready(in_ready),
    .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan), .out_code(out_code)
);

// File: bench/exchange_model.sv
// Exchange-side model: sample source and stalling output sink.
`timescale 1ns/1ps
module exchange_model
    import bridge_pkg::*;
(
    // Clock and bench control.
    input wire logic              core_clk,
    input wire logic              stall,
    input wire logic              clr,
    // Sample source.
    output logic                  in_valid,
    input wire logic              in_ready,
    output logic [CHAN_W-1:0]     in_chan,
    output logic [CODE_W-1:0]     in_code,
    // Sample sink.
    input wire logic              out_valid,
    output logic                  out_ready,
    input wire logic [CHAN_W-1:0] out_chan,
    input wire logic [CODE_W-1:0] out_code
);
    logic [CODE_W-1:0] got [NUM_CHANS];
    int                n_got;
    int                n_hang = 0;

    initial
    begin
        in_valid = 1'b0;
        in_chan = '0;
        in_code = '0;
    end

    always_ff @(posedge core_clk)
        out_ready <= !stall;

    // Collects one routed word per channel; clr empties the record.
    always_ff @(posedge core_clk)
    begin
        if (clr)
        begin
            n_got <= 0;
            for (int i = 0; i < NUM_CHANS; i++)
                got[i] <= 'x;
        end
        else if (out_valid && out_ready)
        begin
            n_got <= n_got + 1;
            got[out_chan] <= out_code;
        end
    end

    // Writes one code into the bridge table; lines are scrambled once released.
    task automatic send(input logic [CHAN_W-1:0] ch, input logic [CODE_W-1:0] code);
        int k;
        in_valid <= 1'b1;
        in_chan <= ch;
        in_code <= code;
        for (k = 0; k < 4000; k++)
        begin
            @(posedge core_clk);
            if (in_ready === 1'b1)
                break;
        end
        if (k == 4000)
            n_hang++;
        in_valid <= 1'b0;
        in_chan <= ~ch;
        in_code <= ~code;
        @(posedge core_clk);
    endtask : send
endmodule : exchange_model

// File: bench/test_loudest_speaker_conference_bridge.sv
// Self-checking bench for the conference bridge.
`timescale 1ns/1ps
module test_loudest_speaker_conference_bridge
    import bridge_pkg::*;
;
    logic              core_clk, srst, read, write, waitrequest;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata;
    logic [3:0]        byteenable;
    logic              in_valid, in_ready, out_valid, out_ready, stall, clr;
    logic [CHAN_W-1:0] in_chan, out_chan;
    logic [CODE_W-1:0] in_code, out_code;
    logic [7:0]        c [8];
    int                n_fail, cmp_count;

    conference_bridge DUT (.core_clk(core_clk), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .in_valid(in_valid), .in_ready(in_ready),
        .in_chan(in_chan), .in_code(in_code), .out_valid(out_valid), .out_ready(out_ready),
        .out_chan(out_chan), .out_code(out_code));
    exchange_model u_exch (.core_clk(core_clk), .stall(stall), .clr(clr),
        .in_valid(in_valid), .in_ready(in_ready), .in_chan(in_chan), .in_code(in_code),
        .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan),
        .out_code(out_code));

    task automatic print_verdict();
        n_fail += u_exch.n_hang;
        $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic hang();
        n_fail++;
        print_verdict();
    endtask : hang

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] q);
        cmp_count++;
        if (q !== e)
        begin
            n_fail++;
            $display("Error %s: expected %h, seen %h", what, e, q);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        for (k = 0; k < 100; k++)
        begin
            @(posedge core_clk);
            if (waitrequest === 1'b0)
                break;
        end
        q = readdata;
        if (k == 100)
            hang();
        write <= 1'b0;
        read <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        chk(what, e, q);
    endtask : rd

    // Waits until a burst has been routed and the output buffer has drained.
    task automatic settle();
        int k;
        for (k = 0; k < 8000; k++)
        begin
            @(posedge core_clk);
            if (in_ready === 1'b1 && out_valid === 1'b0 && u_exch.n_got > 0)
                break;
        end
        if (k == 8000)
            hang();
    endtask : settle

    task automatic clear();
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask : clear

    // Loads one period of codes, optionally stalls the sink, then judges the routing.
    task automatic burst(input int n, input int spk, input logic [7:0] sil, input bit hold);
        int k;
        clear();
        settle();
        for (int i = 0; i < n; i++)
            u_exch.send(i[2:0], c[i]);
        stall <= hold;
        clear();
        for (k = 0; k < 8000 && hold; k++)
        begin
            @(posedge core_clk);
            if (out_valid === 1'b1)
                break;
        end
        if (k == 8000)
            hang();
        repeat (20) @(posedge core_clk);
        stall <= 1'b0;
        settle();
        chk("word count", n, u_exch.n_got);
        for (int i = 0; i < n; i++)
            chk("routed code", (i == spk) ? sil : c[spk], u_exch.got[i]);
    endtask : burst

    task automatic t_regs();
        rd("table base", OFS_TABLE, 32'h0000_0100);
        rd("silence", OFS_SILENCE, 32'h0000_00ff);
        rd("channel count", OFS_NCHANS, 32'h0000_0008);
        rd("unmapped", 8'hfc, 32'h0000_0000);
        wr(OFS_SCALE + 8'h1c, 32'h0000_1234);
        rd("scale 7", OFS_SCALE + 8'h1c, 32'h0000_1234);
        rd("scale 6", OFS_SCALE + 8'h18, 32'h0000_0000);
        wr(OFS_IO + 8'h1c, 32'h0000_005a);
        rd("table word 7", OFS_IO + 8'h1c, 32'h0000_005a);
        wr(OFS_COEF + 8'h0c, 32'h0000_0abc);
        rd("coef 3", OFS_COEF + 8'h0c, 32'h0000_0abc);
        wr(OFS_COEF + 8'h0c, 32'h0000_0000);
    endtask : t_regs

    task automatic t_law();
        wr(OFS_NCHANS, 32'h3);
        for (int i = 0; i < 8; i++)
            wr(OFS_SCALE + 8'(4 * i), 32'h0000_4000);
        c = '{8'h2a, 8'h80, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        burst(3, 1, 8'hff, 1'b0);
        wr(OFS_TABLE, 32'h0000_0180);
        wr(OFS_SILENCE, 32'h0000_00d5);
        burst(3, 0, 8'hd5, 1'b0);
        rd("table word 1", OFS_IO + 8'h04, 32'h0000_002a);
    endtask : t_law

    task automatic t_tie();
        wr(OFS_TABLE, 32'h0000_0100);
        wr(OFS_SILENCE, 32'h0000_00ff);
        wr(OFS_NCHANS, 32'h4);
        c = '{8'h7f, 8'h00, 8'h80, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00};
        burst(4, 1, 8'hff, 1'b1);
    endtask : t_tie

    task automatic t_prio();
        wr(OFS_NCHANS, 32'h3);
        wr(OFS_SCALE + 8'h08, 32'h0000_7fff);
        c = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        burst(3, 2, 8'hff, 1'b0);
        rd("status", OFS_STATUS, 32'h0000_0002);
    endtask : t_prio

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial
    begin
        srst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'hf;
        stall = 1'b0;
        clr = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_law();
        t_tie();
        t_prio();
        print_verdict();
    end
endmodule : test_loudest_speaker_conference_bridge
